// ---- hw/psb_pkg.sv ----
// Shared constants, types and frame helpers for the packet stream backup ends
package psb_pkg;

	// ************************************************************
	// Frame layout
	// ************************************************************
	localparam int unsigned DLCI_W      = 10;
	localparam logic [7:0]  XID_CTRL    = 8'haf;
	localparam logic [7:0]  FMT_WBP     = 8'h83;
	localparam logic [7:0]  GI_BACKUP   = 8'hf5;
	localparam logic [7:0]  GI_SWBACK   = 8'hf7;
	localparam logic        CR_RESPONSE = 1'b1;
	localparam logic        EA_MORE     = 1'b0;
	localparam logic        EA_LAST     = 1'b1;
	localparam logic [2:0]  CONG_BITS   = 3'h0;
	localparam int unsigned CR_POS      = 1;
	localparam int unsigned EA_POS      = 0;

	typedef logic [2:0]      psb_idx_t;
	typedef logic [4:0][7:0] psb_hdr_t;
	typedef logic [DLCI_W-1:0] psb_dlci_t;

	localparam psb_idx_t IDX_A1   = 3'h0;
	localparam psb_idx_t IDX_A2   = 3'h1;
	localparam psb_idx_t IDX_CTRL = 3'h2;
	localparam psb_idx_t IDX_FMT  = 3'h3;
	localparam psb_idx_t IDX_GI   = 3'h4;
	localparam psb_idx_t IDX_F1   = 3'h5;
	localparam psb_idx_t IDX_F2   = 3'h6;

	// ************************************************************
	// Check sequence
	// ************************************************************
	localparam logic [15:0] FCS_INIT = 16'hffff;
	localparam logic [15:0] FCS_POLY = 16'h8408;
	localparam logic [15:0] FCS_GOOD = 16'hf0b8;

	// ************************************************************
	// Alarm indication
	// ************************************************************
	localparam int unsigned CHANS_T1 = 24;
	localparam int unsigned CHANS_E1 = 30;

	typedef enum logic [0:0] {
		PSB_TX_IDLE = 1'b0,
		PSB_TX_SEND = 1'b1
	} psb_tx_e;

	// Bit-serial reflected update, first bit on the wire is bit 0
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ d[i])
				c = (c >> 1) ^ FCS_POLY;
			else
				c = c >> 1;
		end
		return c;
	endfunction : crc_byte

	// Octet idx of a response frame; fcs is the running check after octet 4
	function automatic logic [7:0] frame_octet(input psb_idx_t idx, input psb_dlci_t dlci,
			input logic [7:0] gi, input logic [15:0] fcs);
		logic [15:0] inv;
		inv = ~fcs;
		case (idx)
			IDX_A1:   return {dlci[9:4], CR_RESPONSE, EA_MORE};
			IDX_A2:   return {dlci[3:0], CONG_BITS, EA_LAST};
			IDX_CTRL: return XID_CTRL;
			IDX_FMT:  return FMT_WBP;
			IDX_GI:   return gi;
			IDX_F1:   return inv[7:0];
			IDX_F2:   return inv[15:8];
			default:  return 8'h00;
		endcase
	endfunction : frame_octet

	function automatic logic hdr_ok(input psb_hdr_t h);
		return h[IDX_A1][CR_POS] == CR_RESPONSE && h[IDX_A1][EA_POS] == EA_MORE &&
			h[IDX_A2][EA_POS] == EA_LAST && h[IDX_CTRL] == XID_CTRL &&
			h[IDX_FMT] == FMT_WBP && (h[IDX_GI] == GI_BACKUP || h[IDX_GI] == GI_SWBACK);
	endfunction : hdr_ok

	function automatic psb_dlci_t hdr_dlci(input psb_hdr_t h);
		return {h[IDX_A1][7:2], h[IDX_A2][7:4]};
	endfunction : hdr_dlci

endpackage : psb_pkg

// ---- hw/psb_link_if.sv ----
// Octet link between the detecting node and its peer node
`timescale 1ns/10ps
interface psb_link_if;
	logic       d2p_valid;
	logic [7:0] d2p_data;
	logic       d2p_last;
	logic       d2p_bkup;
	logic       p2d_valid;
	logic [7:0] p2d_data;
	logic       p2d_last;
	logic       p2d_bkup;

	modport dev (
		output d2p_valid,
		output d2p_data,
		output d2p_last,
		output d2p_bkup,
		input  p2d_valid,
		input  p2d_data,
		input  p2d_last,
		input  p2d_bkup
	);

	modport peer (
		input  d2p_valid,
		input  d2p_data,
		input  d2p_last,
		input  d2p_bkup,
		output p2d_valid,
		output p2d_data,
		output p2d_last,
		output p2d_bkup
	);
endinterface : psb_link_if

// ---- hw/psb_node.sv ----
// Detecting node end: fault and clearance frames, relay, traffic switch, alarm indication
`timescale 1ns/10ps

// Contract
// [RULE1] Fault detected: send backup response frame
// [RULE2] Backup frame group octet is 245
// [RULE3] Terminating receiver moves traffic to backup
// [RULE4] Transit receiver relays with translated address
// [RULE5] Fault cleared: send frame on backup link
// [RULE6] Clearance frame group octet is 247
// [RULE7] Terminating receiver returns traffic to primary
// [RULE8] Transit clearance relayed with translated address
// [RULE9] Last two octets are the check sequence
// [RULE10] Send alarm indication downstream on failure
// [RULE11] Alarm only when all channels share stream
// [RULE12] Alarm needs primary failed, backup absent/failed
// [RULE13] Alarm only without circuit backups; else declared
// [RULE14] Format octet is 131
// [RULE15] Command/response bit set to one
// [RULE16] Only edge nodes act; transit relays
// [RULE17] Sixteen-bit check; bad frames discarded
// [RULE18] Identification control octet; seven octet frame
module psb_node
	import psb_pkg::*;
#(
	parameter int unsigned CH_T1 = CHANS_T1,
	parameter int unsigned CH_E1 = CHANS_E1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	psb_link_if.dev               link,
	input  wire logic             fault_det,
	input  wire psb_pkg::psb_dlci_t stream_dlci,
	input  wire logic             terminates,
	input  wire psb_pkg::psb_dlci_t relay_dlci,
	input  wire logic             iface_e1,
	input  wire logic [4:0]       chans_on_stream,
	input  wire logic             backup_present,
	input  wire logic             backup_failed,
	input  wire logic             pvc_backup_any,
	output logic                  use_backup,
	output logic                  ais,
	output logic                  rx_drop
);
	import psb_pkg::*;

	// Channel count must fit the five-bit count input
	if (CH_T1 == 0 || CH_E1 == 0 || CH_T1 > 31 || CH_E1 > 31) begin : g_bad_chans
		$error("channel counts must be 1..31");
	end

	// ************************************************************
	// Receive parser
	// ************************************************************
	psb_idx_t    rx_cnt_q;
	logic        rx_long_q;
	logic [15:0] rx_crc_q;
	psb_hdr_t    rx_hdr_q;
	logic        rx_end;
	logic        rx_good;
	logic [7:0]  rx_gi;

	assign rx_end  = link.p2d_valid && link.p2d_last;
	assign rx_gi   = rx_hdr_q[IDX_GI];
	assign rx_good = rx_end && !rx_long_q && rx_cnt_q == IDX_F2 && hdr_ok(rx_hdr_q) && // RULE14
		crc_byte(rx_crc_q, link.p2d_data) == FCS_GOOD; // RULE9 RULE17

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_q  <= IDX_A1;
			rx_long_q <= 1'b0;
			rx_crc_q  <= FCS_INIT;
		end else if (link.p2d_valid) begin
			if (link.p2d_last) begin
				rx_cnt_q  <= IDX_A1;
				rx_long_q <= 1'b0;
				rx_crc_q  <= FCS_INIT;
			end else begin
				if (rx_cnt_q == IDX_F2)
					rx_long_q <= 1'b1;
				else
					rx_cnt_q <= rx_cnt_q + 3'h1;
				rx_crc_q <= crc_byte(rx_crc_q, link.p2d_data);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_hdr_q <= '0;
		else if (link.p2d_valid && !link.p2d_last && rx_cnt_q < IDX_F1)
			rx_hdr_q[rx_cnt_q] <= link.p2d_data;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_drop <= 1'b0;
		else
			rx_drop <= rx_end && !rx_good; // RULE17
	end

	// ************************************************************
	// Fault edges and pending frames
	// ************************************************************
	logic      fault_q;
	logic      pend_fault_q;
	logic      pend_clear_q;
	logic      pend_relay_q;
	logic [7:0] relay_gi_q;
	logic      take_fault;
	logic      take_clear;
	logic      take_relay;
	logic      fault_rise;
	logic      fault_fall;
	logic      relay_req;
	psb_tx_e   tx_state_q;

	assign fault_rise = fault_det && !fault_q;
	assign fault_fall = !fault_det && fault_q;
	// Transit nodes never act on the group codes, they only forward
	assign relay_req  = rx_good && !terminates; // RULE16
	assign take_fault = tx_state_q == PSB_TX_IDLE && pend_fault_q;
	assign take_clear = tx_state_q == PSB_TX_IDLE && !pend_fault_q && pend_clear_q;
	assign take_relay = tx_state_q == PSB_TX_IDLE && !pend_fault_q && !pend_clear_q &&
		pend_relay_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fault_q <= 1'b0;
		else
			fault_q <= fault_det;
	end

	// A new edge wins over the take of an older request in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_fault_q <= 1'b0;
			pend_clear_q <= 1'b0;
		end else if (fault_rise) begin
			pend_fault_q <= 1'b1; // RULE1
			pend_clear_q <= 1'b0;
		end else if (fault_fall) begin
			pend_clear_q <= 1'b1; // RULE5
			pend_fault_q <= 1'b0;
		end else begin
			if (take_fault)
				pend_fault_q <= 1'b0;
			if (take_clear)
				pend_clear_q <= 1'b0;
		end
	end

	// One relay slot; a newer frame overwrites a waiting one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_relay_q <= 1'b0;
			relay_gi_q   <= GI_BACKUP;
		end else if (relay_req) begin
			pend_relay_q <= 1'b1; // RULE4 RULE8
			relay_gi_q   <= rx_gi;
		end else if (take_relay) begin
			pend_relay_q <= 1'b0;
		end
	end

	// ************************************************************
	// Traffic switch and alarm indication
	// ************************************************************
	logic all_chans;

	assign all_chans = iface_e1 ? chans_on_stream == 5'(CH_E1) :
		chans_on_stream == 5'(CH_T1);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			use_backup <= 1'b0;
		else if (fault_rise)
			use_backup <= 1'b1;
		else if (fault_fall)
			use_backup <= 1'b0;
		else if (rx_good && terminates && rx_gi == GI_BACKUP)
			use_backup <= 1'b1; // RULE3
		else if (rx_good && terminates && rx_gi == GI_SWBACK)
			use_backup <= 1'b0; // RULE7
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ais <= 1'b0;
		else
			ais <= all_chans && // RULE11
				fault_det && (!backup_present || backup_failed) && // RULE12
				!pvc_backup_any; // RULE10 RULE13
	end

	// ************************************************************
	// Frame transmitter
	// ************************************************************
	psb_idx_t    tx_idx_q;
	logic [7:0]  tx_gi_q;
	psb_dlci_t   tx_dlci_q;
	logic [15:0] tx_crc_q;
	logic [7:0]  tx_octet;
	logic        tx_valid_q;
	logic        tx_last_q;
	logic        tx_bkup_q;
	logic [7:0]  tx_data_q;

	assign tx_octet = frame_octet(tx_idx_q, tx_dlci_q, tx_gi_q, tx_crc_q); // RULE15 RULE18

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= PSB_TX_IDLE;
			tx_idx_q   <= IDX_A1;
			tx_gi_q    <= GI_BACKUP;
			tx_dlci_q  <= '0;
			tx_bkup_q  <= 1'b0;
		end else begin
			case (tx_state_q)
				PSB_TX_IDLE: begin
					tx_idx_q <= IDX_A1;
					if (take_fault) begin
						tx_state_q <= PSB_TX_SEND;
						tx_gi_q    <= GI_BACKUP; // RULE2
						tx_dlci_q  <= stream_dlci;
						tx_bkup_q  <= 1'b0;
					end else if (take_clear) begin
						tx_state_q <= PSB_TX_SEND;
						tx_gi_q    <= GI_SWBACK; // RULE6
						tx_dlci_q  <= stream_dlci;
						tx_bkup_q  <= 1'b1; // RULE5
					end else if (take_relay) begin
						tx_state_q <= PSB_TX_SEND;
						tx_gi_q    <= relay_gi_q;
						tx_dlci_q  <= relay_dlci; // RULE4 RULE8
						tx_bkup_q  <= 1'b0;
					end
				end
				PSB_TX_SEND: begin
					tx_idx_q <= tx_idx_q + 3'h1;
					if (tx_idx_q == IDX_F2)
						tx_state_q <= PSB_TX_IDLE;
				end
				default: tx_state_q <= PSB_TX_IDLE;
			endcase
		end
	end

	// Check covers address through group octet only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tx_crc_q <= FCS_INIT;
		else if (tx_state_q == PSB_TX_IDLE)
			tx_crc_q <= FCS_INIT;
		else if (tx_idx_q < IDX_F1)
			tx_crc_q <= crc_byte(tx_crc_q, tx_octet); // RULE9 RULE17
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
			tx_last_q  <= 1'b0;
			tx_data_q  <= 8'h00;
		end else begin
			tx_valid_q <= tx_state_q == PSB_TX_SEND;
			tx_last_q  <= tx_state_q == PSB_TX_SEND && tx_idx_q == IDX_F2; // RULE18
			tx_data_q  <= tx_state_q == PSB_TX_SEND ? tx_octet : 8'h00;
		end
	end

	assign link.d2p_valid = tx_valid_q;
	assign link.d2p_data  = tx_data_q;
	assign link.d2p_last  = tx_last_q;
	assign link.d2p_bkup  = tx_valid_q && tx_bkup_q;

endmodule : psb_node

// ---- hw/psb_peer.sv ----
// Far-end packet node: originates on request, switches traffic or relays received frames
`timescale 1ns/10ps
module psb_peer
	import psb_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	psb_link_if.peer              link,
	input  wire logic             req_backup,
	input  wire logic             req_switch,
	input  wire psb_pkg::psb_dlci_t req_dlci,
	input  wire logic             terminates,
	input  wire psb_pkg::psb_dlci_t relay_dlci,
	output logic                  use_backup,
	output logic                  rx_drop
);
	import psb_pkg::*;

	// ************************************************************
	// Receive parser
	// ************************************************************
	psb_idx_t    rx_cnt_q;
	logic        rx_long_q;
	logic [15:0] rx_crc_q;
	psb_hdr_t    rx_hdr_q;
	logic        rx_end;
	logic        rx_good;
	logic [7:0]  rx_gi;

	assign rx_end  = link.d2p_valid && link.d2p_last;
	assign rx_gi   = rx_hdr_q[IDX_GI];
	assign rx_good = rx_end && !rx_long_q && rx_cnt_q == IDX_F2 && hdr_ok(rx_hdr_q) && // RULE14
		crc_byte(rx_crc_q, link.d2p_data) == FCS_GOOD; // RULE9 RULE17

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_q  <= IDX_A1;
			rx_long_q <= 1'b0;
			rx_crc_q  <= FCS_INIT;
		end else if (link.d2p_valid) begin
			if (link.d2p_last) begin
				rx_cnt_q  <= IDX_A1;
				rx_long_q <= 1'b0;
				rx_crc_q  <= FCS_INIT;
			end else begin
				if (rx_cnt_q == IDX_F2)
					rx_long_q <= 1'b1;
				else
					rx_cnt_q <= rx_cnt_q + 3'h1;
				rx_crc_q <= crc_byte(rx_crc_q, link.d2p_data);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_hdr_q <= '0;
		else if (link.d2p_valid && !link.d2p_last && rx_cnt_q < IDX_F1)
			rx_hdr_q[rx_cnt_q] <= link.d2p_data;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_drop    <= 1'b0;
			use_backup <= 1'b0;
		end else begin
			rx_drop <= rx_end && !rx_good; // RULE17
			if (rx_good && terminates && rx_gi == GI_BACKUP)
				use_backup <= 1'b1; // RULE3 RULE16
			else if (rx_good && terminates && rx_gi == GI_SWBACK)
				use_backup <= 1'b0; // RULE7
		end
	end

	// ************************************************************
	// Requests and transmitter
	// ************************************************************
	logic        pend_q;
	logic [7:0]  pend_gi_q;
	psb_dlci_t   pend_dlci_q;
	logic        take;
	psb_tx_e     tx_state_q;
	psb_idx_t    tx_idx_q;
	logic [7:0]  tx_gi_q;
	psb_dlci_t   tx_dlci_q;
	logic [15:0] tx_crc_q;
	logic [7:0]  tx_octet;
	logic        tx_valid_q;
	logic        tx_last_q;
	logic [7:0]  tx_data_q;

	assign take     = tx_state_q == PSB_TX_IDLE && pend_q;
	assign tx_octet = frame_octet(tx_idx_q, tx_dlci_q, tx_gi_q, tx_crc_q); // RULE18

	// Relays outrank local requests; newest request wins a single slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q      <= 1'b0;
			pend_gi_q   <= GI_BACKUP;
			pend_dlci_q <= '0;
		end else if (rx_good && !terminates) begin
			pend_q      <= 1'b1;
			pend_gi_q   <= rx_gi;
			pend_dlci_q <= relay_dlci; // RULE4 RULE8
		end else if (req_backup || req_switch) begin
			pend_q      <= 1'b1;
			pend_gi_q   <= req_backup ? GI_BACKUP : GI_SWBACK;
			pend_dlci_q <= req_dlci;
		end else if (take) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= PSB_TX_IDLE;
			tx_idx_q   <= IDX_A1;
			tx_gi_q    <= GI_BACKUP;
			tx_dlci_q  <= '0;
		end else begin
			case (tx_state_q)
				PSB_TX_IDLE: begin
					tx_idx_q <= IDX_A1;
					if (take) begin
						tx_state_q <= PSB_TX_SEND;
						tx_gi_q    <= pend_gi_q;
						tx_dlci_q  <= pend_dlci_q;
					end
				end
				PSB_TX_SEND: begin
					tx_idx_q <= tx_idx_q + 3'h1;
					if (tx_idx_q == IDX_F2)
						tx_state_q <= PSB_TX_IDLE;
				end
				default: tx_state_q <= PSB_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tx_crc_q <= FCS_INIT;
		else if (tx_state_q == PSB_TX_IDLE)
			tx_crc_q <= FCS_INIT;
		else if (tx_idx_q < IDX_F1)
			tx_crc_q <= crc_byte(tx_crc_q, tx_octet); // RULE9 RULE17
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
			tx_last_q  <= 1'b0;
			tx_data_q  <= 8'h00;
		end else begin
			tx_valid_q <= tx_state_q == PSB_TX_SEND;
			tx_last_q  <= tx_state_q == PSB_TX_SEND && tx_idx_q == IDX_F2;
			tx_data_q  <= tx_state_q == PSB_TX_SEND ? tx_octet : 8'h00;
		end
	end

	assign link.p2d_valid = tx_valid_q;
	assign link.p2d_data  = tx_data_q;
	assign link.p2d_last  = tx_last_q;
	assign link.p2d_bkup  = tx_valid_q && tx_gi_q == GI_SWBACK;

endmodule : psb_peer

// ---- tb/psb_link_assertions.sv ----
// Concurrent checks on the octet link joining the node and its peer
`timescale 1ns/10ps
module psb_link_assertions
	import psb_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       d2p_valid,
	input wire logic [7:0] d2p_data,
	input wire logic       d2p_last,
	input wire logic       d2p_bkup,
	input wire logic       p2d_valid,
	input wire logic [7:0] p2d_data,
	input wire logic       p2d_last,
	input wire logic       p2d_bkup
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ********************
	// Node to peer
	// ********************
	chk_frame_len: assert property (
		$rose(d2p_valid) |-> d2p_valid[*7] ##1 !d2p_valid)
		else $error("node frame is not seven octets");
	chk_last_place: assert property (
		$rose(d2p_valid) |-> (!d2p_last)[*6] ##1 d2p_last)
		else $error("node frame end marker misplaced");
	chk_header_octets: assert property (
		$rose(d2p_valid) |-> d2p_data[1:0] == 2'b10 ##1 d2p_data[0] ##1
		d2p_data == 8'haf ##1 d2p_data == 8'h83)
		else $error("node frame header octets wrong");
	chk_group_code: assert property (
		$rose(d2p_valid) ##4 1'b1 |-> d2p_data inside {8'hf5, 8'hf7})
		else $error("node frame group octet wrong");
	chk_bkup_clear: assert property (
		$rose(d2p_valid) && d2p_bkup |-> ##4 d2p_data == 8'hf7)
		else $error("backup link frame is not a clearance");
	chk_bkup_steady: assert property (
		d2p_valid && !d2p_last |=> $stable(d2p_bkup))
		else $error("backup link marker changed inside frame");
	chk_idle_zero: assert property (
		!d2p_valid |-> d2p_data == 8'h00)
		else $error("node data not zero while idle");

	// ********************
	// Peer to node
	// ********************
	chk_peer_len: assert property (
		$rose(p2d_valid) |-> p2d_valid[*7] ##1 !p2d_valid)
		else $error("peer frame is not seven octets");
	chk_peer_last: assert property (
		$rose(p2d_valid) |-> (!p2d_last)[*6] ##1 p2d_last)
		else $error("peer frame end marker misplaced");
	chk_peer_bkup: assert property (
		$rose(p2d_valid) ##4 1'b1 |-> p2d_bkup == (p2d_data == 8'hf7))
		else $error("peer backup marker disagrees with group");
endmodule : psb_link_assertions

// ---- tb/tb_top.sv ----
// Bench: node and peer face each other; a second node faces a rule-breaking driver
`timescale 1ns/10ps
module tb_top;
	import psb_pkg::*;

	typedef logic [6:0][7:0] psb_frame_t;

	logic            ref_clk, rst_n, fault, term1, term2, termp, e1, bp, bf, pvc, rqb, rqs;
	logic            ub1, ais1, dr1, ubp, drp, ub2, ais2, dr2;
	logic [4:0]      chans;
	psb_dlci_t       sdl, rdl, rdlp, rqd;
	logic [56:0]     q[3][$];
	psb_frame_t      cap[3];
	int              cnt[3] = '{0, 0, 0};
	int              fails = 0, n_tests = 0, nd1 = 0, ndp = 0, nd2 = 0;

	psb_link_if l1 ();
	psb_link_if l2 ();

	psb_node i_psb_node (.ref_clk(ref_clk), .rst_n(rst_n), .link(l1), .fault_det(fault),
		.stream_dlci(sdl), .terminates(term1), .relay_dlci(rdl), .iface_e1(e1),
		.chans_on_stream(chans), .backup_present(bp), .backup_failed(bf), .pvc_backup_any(pvc),
		.use_backup(ub1), .ais(ais1), .rx_drop(dr1));
	psb_node i_psb_node_2 (.ref_clk(ref_clk), .rst_n(rst_n), .link(l2), .fault_det(fault),
		.stream_dlci(sdl), .terminates(term2), .relay_dlci(rdl), .iface_e1(e1),
		.chans_on_stream(chans), .backup_present(bp), .backup_failed(bf), .pvc_backup_any(pvc),
		.use_backup(ub2), .ais(ais2), .rx_drop(dr2));
	psb_peer i_psb_peer (.ref_clk(ref_clk), .rst_n(rst_n), .link(l1), .req_backup(rqb),
		.req_switch(rqs), .req_dlci(rqd), .terminates(termp), .relay_dlci(rdlp),
		.use_backup(ubp), .rx_drop(drp));
	psb_link_assertions i_psb_link_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
		.d2p_valid(l1.d2p_valid), .d2p_data(l1.d2p_data), .d2p_last(l1.d2p_last),
		.d2p_bkup(l1.d2p_bkup), .p2d_valid(l1.p2d_valid), .p2d_data(l1.p2d_data),
		.p2d_last(l1.p2d_last), .p2d_bkup(l1.p2d_bkup));

	wire [2:0]  mv = {l2.d2p_valid, l1.p2d_valid, l1.d2p_valid};
	wire [2:0]  ml = {l2.d2p_last, l1.p2d_last, l1.d2p_last};
	wire [2:0]  mb = {l2.d2p_bkup, l1.p2d_bkup, l1.d2p_bkup};
	wire [23:0] md = {l2.d2p_data, l1.p2d_data, l1.d2p_data};

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ********************
	// Compare and report
	// ********************
	task automatic chk_frame(input logic [56:0] got, input logic [56:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_frame

	task automatic chk_lvl(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_lvl

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// ********************
	// Frame building
	// ********************
	// Own reflected check so a shared slip with the design cannot hide
	function automatic psb_frame_t seal(input psb_frame_t f);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < 40; i++)
			c = (c[0] ^ f[i / 8][i % 8]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		f[5] = ~c[7:0];
		f[6] = ~c[15:8];
		return f;
	endfunction : seal

	function automatic psb_frame_t frm(input psb_dlci_t d, input logic [7:0] gi);
		psb_frame_t f;
		f = '0;
		f[0] = {d[9:4], 2'b10};
		f[1] = {d[3:0], 4'h1};
		f[2] = 8'haf;
		f[3] = 8'h83;
		f[4] = gi;
		return seal(f);
	endfunction : frm

	task automatic push(input int k, input psb_frame_t f, input logic bk);
		q[k].push_back({bk, f});
	endtask : push

	task automatic settle();
		int i;
		for (i = 0; i < 300 && (q[0].size() + q[1].size() + q[2].size()) > 0; i++)
			@(posedge ref_clk);
		if (i == 300) begin
			fails++;
			wrap_up();
		end else
			repeat (6) @(posedge ref_clk);
	endtask : settle

	// Second link: bench stands in for the peer and may break the frame rules
	task automatic send(input psb_frame_t f, input int n, input logic bk);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			l2.p2d_valid <= 1'b1;
			l2.p2d_data  <= f[i];
			l2.p2d_last  <= (i == n - 1);
			l2.p2d_bkup  <= bk;
		end
		@(posedge ref_clk);
		{l2.p2d_valid, l2.p2d_last, l2.p2d_bkup} <= 3'h0;
		l2.p2d_data <= ~f[n - 1];
	endtask : send

	// ********************
	// Monitors
	// ********************
	always @(posedge ref_clk) begin
		logic [56:0] e;
		for (int k = 0; k < 3; k++) begin
			if (rst_n && mv[k]) begin
				cap[k][cnt[k] % 7] = md[k * 8 +: 8];
				cnt[k]++;
				e = '1;
				if (ml[k] && q[k].size() > 0)
					e = q[k].pop_front();
				if (ml[k]) begin
					chk_frame({mb[k], cap[k]}, e);
					cnt[k] = 0;
				end
			end
		end
	end

	always @(posedge ref_clk) begin
		nd1 += int'(dr1 === 1'b1);
		ndp += int'(drp === 1'b1);
		nd2 += int'(dr2 === 1'b1);
	end

	// ********************
	// Scenarios
	// ********************
	initial begin
		psb_dlci_t  d;
		psb_frame_t f;
		int         c0;
		rst_n = 1'b0;
		{fault, termp, e1, bp, bf, pvc, rqb, rqs} = '0;
		{term1, term2} = 2'b11;
		chans = 5'h18;
		{l2.p2d_valid, l2.p2d_last, l2.p2d_bkup} = 3'h0;
		l2.p2d_data = 8'h00;
		void'($urandom(13));
		sdl = psb_dlci_t'($urandom);
		rdl = psb_dlci_t'($urandom);
		rdlp = psb_dlci_t'($urandom);
		rqd = '0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Own fault and clearance; peer terminating, then peer in transit
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk);
			termp <= (p == 0);
			fault <= 1'b1;
			push(0, frm(sdl, 8'hf5), 1'b0);
			push(2, frm(sdl, 8'hf5), 1'b0);
			if (p == 1)
				push(1, frm(rdlp, 8'hf5), 1'b0);
			settle();
			chk_lvl(8'(ub1), 8'h01);
			chk_lvl(8'(ubp), 8'(p == 0));
			for (int k = 0; k < 32; k++) begin
				@(posedge ref_clk);
				e1 <= k[4];
				chans <= (k[3] == k[4]) ? 5'h1e : 5'h18;
				{bp, bf, pvc} <= 3'(k);
				repeat (2) @(posedge ref_clk);
				chk_lvl(8'(ais1), 8'(k[3] & (!k[2] | k[1]) & !k[0]));
				chk_lvl(8'(ais2), 8'(k[3] & (!k[2] | k[1]) & !k[0]));
			end
			@(posedge ref_clk);
			{e1, bp, pvc} <= 3'h0;
			chans <= 5'h18;
			fault <= 1'b0;
			push(0, frm(sdl, 8'hf7), 1'b1);
			push(2, frm(sdl, 8'hf7), 1'b1);
			if (p == 1)
				push(1, frm(rdlp, 8'hf7), 1'b1);
			settle();
			chk_lvl(8'(ais1), 8'h00);
			chk_lvl(8'(ub1), 8'h00);
			chk_lvl(8'(ubp), 8'h00);
		end
		// Peer originates; node terminating, then node in transit
		for (int p = 0; p < 2; p++) begin
			d = psb_dlci_t'($urandom);
			@(posedge ref_clk);
			term1 <= (p == 0);
			termp <= (p == 1);
			rqd <= d;
			rqb <= 1'b1;
			@(posedge ref_clk);
			rqb <= 1'b0;
			push(1, frm(d, 8'hf5), 1'b0);
			if (p == 1)
				push(0, frm(rdl, 8'hf5), 1'b0);
			settle();
			chk_lvl(8'(ub1), 8'(p == 0));
			if (p == 1)
				chk_lvl(8'(ubp), 8'h01);
			@(posedge ref_clk);
			rqs <= 1'b1;
			@(posedge ref_clk);
			rqs <= 1'b0;
			push(1, frm(d, 8'hf7), 1'b1);
			if (p == 1)
				push(0, frm(rdl, 8'hf7), 1'b0);
			settle();
			chk_lvl(8'(ub1), 8'h00);
			chk_lvl(8'(ubp), 8'h00);
		end
		// Good backup frame, then broken frames into the second node; last case is a transit relay
		for (int k = 0; k < 8; k++) begin
			d = psb_dlci_t'($urandom);
			// Broken frames except the bad group case carry the switchback code, so a wrongly accepted one clears ub2
			f = frm(d, (k == 0) ? 8'hf5 : 8'hf7);
			case (k)
				2: f[3] = 8'h84;
				3: f[0][1] = 1'b0;
				4: f[4] = 8'hf6;
				6: f[2] = 8'hae;
				default: ;
			endcase
			f = seal(f);
			if (k == 1)
				f[6] = f[6] ^ 8'h01;
			@(posedge ref_clk);
			term2 <= (k != 7);
			c0 = nd2;
			send(f, (k == 5) ? 6 : 7, k == 7);
			if (k == 7)
				push(2, frm(rdl, 8'hf7), 1'b0);
			settle();
			chk_lvl(8'(nd2 - c0), 8'(k > 0 && k < 7));
			chk_lvl(8'(ub2), 8'h01);
		end
		chk_lvl(8'(nd1 + ndp), 8'h00);
		wrap_up();
	end
endmodule : tb_top
